// File: ldc_periph_model.sv
// peripheral side model: request pins of the eight channels
// assumes the bench says which channels want service, active high
`timescale 1ns/1ns
module ldc_periph_model
(
    input wire logic [7:0] want,
    input wire logic [1:0] req_low,
    output logic [7:0] channel_request_line
);
    // ------------------------------------------------------------
    // pin level follows the programmed group polarity
    // ------------------------------------------------------------
    assign channel_request_line =
        want ^ {{4{req_low[1]}}, {4{req_low[0]}}};
endmodule // ldc_periph_model

// File: ldc_pkg.sv
// constants and types of the legacy dma channel control block
// assumes one 10 MHz system clock and host i/o cycles one clock long
package ldc_pkg;

    // -----------------------------------------------------------------
    // i/o addresses, index 0 low group, index 1 high group
    // -----------------------------------------------------------------
    localparam int LDC_GROUPS = 2;
    localparam int LDC_CH_PER_GRP = 4;
    localparam int LDC_CHANS = 8;
    localparam logic [1:0][15:0] LDC_ADDR_CMD = {16'h00D0, 16'h0008};
    localparam logic [1:0][15:0] LDC_ADDR_SREQ = {16'h00D2, 16'h0009};
    localparam logic [1:0][15:0] LDC_ADDR_SMASK = {16'h00D4, 16'h000A};
    localparam logic [1:0][15:0] LDC_ADDR_MODE = {16'h00D6, 16'h000B};
    localparam logic [1:0][15:0] LDC_ADDR_PCLR = {16'h00D8, 16'h000C};
    localparam logic [1:0][15:0] LDC_ADDR_MCLR = {16'h00DA, 16'h000D};
    localparam logic [1:0][15:0] LDC_ADDR_MSKCLR = {16'h00DC, 16'h000E};
    localparam logic [1:0][15:0] LDC_ADDR_TIMING = {16'h04D6, 16'h040B};
    localparam logic [15:0] LDC_ADDR_ALLMASK = 16'h00DE;

    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int LDC_CMD_DIS_BIT = 2;
    localparam int LDC_CMD_REQ_POL_BIT = 6;
    localparam int LDC_CMD_ACK_POL_BIT = 7;
    localparam logic [7:0] LDC_CMD_WMASK = 8'hC4;
    localparam int LDC_SEL_LSB = 0;
    localparam int LDC_SEL_W = 2;
    localparam int LDC_SET_BIT = 2;
    localparam int LDC_MODE_TYPE_LSB = 2;
    localparam int LDC_MODE_AUTO_BIT = 4;
    localparam int LDC_MODE_DEC_BIT = 5;
    localparam int LDC_MODE_XM_LSB = 6;
    localparam int LDC_TIM_LSB = 2;
    localparam logic [7:0] LDC_CMD_RST = 8'h00;
    localparam logic [3:0] LDC_MASK_RST = 4'hF;
    localparam logic [3:0] LDC_ZERO4 = 4'h0;
    localparam logic [7:0] LDC_TEMP_VAL = 8'h00;
    localparam logic [7:0] LDC_RD_NONE = 8'h00;
    localparam logic [1:0] LDC_TIM_RST = 2'h0;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        LDC_OP_LEGACY,
        LDC_OP_DIST_MASTER,
        LDC_OP_DIST_SLAVE
    } ldc_opmode_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ldc_io_req_type;

    typedef struct packed {
        logic [1:0] xfer_mode;
        logic addr_dec;
        logic auto_init;
        logic [1:0] xfer_type;
    } ldc_mode_type;

    localparam ldc_mode_type LDC_MODE_RST = '0;

endpackage

// File: ldc_top.sv
// legacy dma channel control: command, request, mask, mode, timing regs
// assumes host i/o cycles as one-clock strobes on clk_sys, request
// pins asynchronous, terminal count and acknowledge from the engine
//
// Behaviour
// RQ1 - command bit 2 set disables all four channels of that group
// RQ2 - command bit 6 picks request polarity, 0 high, 1 low
// RQ3 - command bit 7 picks acknowledge polarity, 0 low, 1 high
// RQ4 - soft request write sets or clears one channel's request bit
// RQ5 - single mask write sets or clears only the selected mask bit
// RQ6 - one mask set per group shared by every mask writer
// RQ7 - mode bits 3-2 store the channel's transfer type
// RQ8 - mode bit 4 enables autoinitialisation of the channel
// RQ9 - mode bit 5 picks address count up or down
// RQ10 - mode bits 7-6 store demand, single or block mode
// RQ11 - timing register bits 3-2 store cycle timing, reset zero
// RQ12 - timing registers always decode; others silent in slave mode
// RQ13 - any write to pointer clear resets that group's byte pointer
// RQ14 - both byte pointers are zero after reset
// RQ15 - master clear resets command, status, requests, masks, pointer
// RQ16 - read at master clear address returns temporary value zero
// RQ17 - any write to clear mask unmasks all four channels
// RQ18 - all mask register reads and writes the four high masks
// RQ19 - masked or disabled channel never starts service
// RQ20 - reserved bits ignored; mode writes touch selected channel only
// RQ21 - operating mode follows remap enable and slave select bits
// RQ22 - status holds terminal counts low, requests high; master clears
`timescale 1ns/1ns
module ldc_top
    import ldc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input ldc_pkg::ldc_io_req_type io_req,
    output logic [7:0] io_rdata,
    output logic io_claim,
    input wire logic remap_en,
    input wire logic slave_sel,
    output ldc_pkg::ldc_opmode_type op_mode,
    input wire logic [7:0] channel_request_line,
    output logic [7:0] channel_acknowledge_line,
    input wire logic [7:0] engine_ack,
    input wire logic [7:0] engine_tc,
    input wire logic [1:0] byte_ptr_flip,
    output logic [1:0] byte_ptr,
    output logic [7:0] service_req,
    output ldc_pkg::ldc_mode_type [7:0] chan_mode,
    output logic [7:0][1:0] chan_timing
);
    import ldc_pkg::*;

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    function automatic logic hit(input ldc_io_req_type r,
                                 input logic [15:0] a);
        return r.addr == a;
    endfunction

    function automatic logic [2:0] chan_of(input int g,
                                           input logic [7:0] d);
        return {g[0], d[LDC_SEL_LSB +: LDC_SEL_W]};
    endfunction

    logic legacy_ok;
    logic [1:0] wr_cmd, wr_sreq, wr_smask, wr_mode, wr_pclr;
    logic [1:0] wr_mclr, wr_mskclr, wr_tim, rd_stat, rd_temp;
    logic wr_all, rd_all;

    always_comb
    begin
        if (remap_en) // RQ21
            op_mode = LDC_OP_DIST_MASTER;
        else if (slave_sel)
            op_mode = LDC_OP_DIST_SLAVE;
        else
            op_mode = LDC_OP_LEGACY;
    end

    assign legacy_ok = op_mode != LDC_OP_DIST_SLAVE; // RQ12

    always_comb
    begin
        for (int g = 0; g < LDC_GROUPS; g++)
        begin
            wr_cmd[g] = io_req.wr & legacy_ok & hit(io_req, LDC_ADDR_CMD[g]);
            wr_sreq[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_SREQ[g]);
            wr_smask[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_SMASK[g]);
            wr_mode[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_MODE[g]);
            wr_pclr[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_PCLR[g]);
            wr_mclr[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_MCLR[g]);
            wr_mskclr[g] = io_req.wr & legacy_ok
                & hit(io_req, LDC_ADDR_MSKCLR[g]);
            wr_tim[g] = io_req.wr & hit(io_req, LDC_ADDR_TIMING[g]); // RQ12
            rd_stat[g] = io_req.rd & legacy_ok
                & hit(io_req, LDC_ADDR_CMD[g]);
            rd_temp[g] = io_req.rd & legacy_ok
                & hit(io_req, LDC_ADDR_MCLR[g]);
        end
    end

    assign wr_all = io_req.wr & legacy_ok & hit(io_req, LDC_ADDR_ALLMASK);
    assign rd_all = io_req.rd & legacy_ok & hit(io_req, LDC_ADDR_ALLMASK);
    assign io_claim = (|{wr_cmd, wr_sreq, wr_smask, wr_mode, wr_pclr,
        wr_mclr, wr_mskclr, wr_tim, rd_stat, rd_temp}) | wr_all | rd_all;

    // -----------------------------------------------------------------
    // command registers
    // -----------------------------------------------------------------
    logic [1:0][7:0] cmd_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cmd_q <= {LDC_CMD_RST, LDC_CMD_RST};
        else
            for (int g = 0; g < LDC_GROUPS; g++)
            begin
                if (wr_mclr[g])
                    cmd_q[g] <= LDC_CMD_RST; // RQ15
                else if (wr_cmd[g])
                    cmd_q[g] <= io_req.wdata & LDC_CMD_WMASK; // RQ20
            end
    end

    // -----------------------------------------------------------------
    // request pin synchroniser and polarity
    // -----------------------------------------------------------------
    logic [7:0] req_s1_q, req_s2_q, req_s3_q, req_pin_q, hw_req;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_s1_q <= '0;
            req_s2_q <= '0;
            req_s3_q <= '0;
            req_pin_q <= '0;
        end
        else
        begin
            req_s1_q <= channel_request_line;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            for (int i = 0; i < LDC_CHANS; i++)
                if (req_s2_q[i] == req_s3_q[i])
                    req_pin_q[i] <= req_s2_q[i];
        end
    end

    always_comb
    begin
        for (int i = 0; i < LDC_CHANS; i++)
            hw_req[i] = req_pin_q[i]
                ^ cmd_q[i / LDC_CH_PER_GRP][LDC_CMD_REQ_POL_BIT]; // RQ2
    end

    // -----------------------------------------------------------------
    // software requests
    // -----------------------------------------------------------------
    logic [7:0] sw_req_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            sw_req_q <= '0;
        else
            for (int g = 0; g < LDC_GROUPS; g++)
                for (int c = 0; c < LDC_CH_PER_GRP; c++)
                begin
                    if (wr_mclr[g])
                        sw_req_q[g * 4 + c] <= 1'b0; // RQ15
                    else if (wr_sreq[g]
                        && chan_of(g, io_req.wdata) == 3'(g * 4 + c))
                        sw_req_q[g * 4 + c] <=
                            io_req.wdata[LDC_SET_BIT]; // RQ4
                    else if (engine_tc[g * 4 + c])
                        sw_req_q[g * 4 + c] <= 1'b0;
                end
    end

    // -----------------------------------------------------------------
    // mask flip-flops, one set per group
    // -----------------------------------------------------------------
    logic [1:0][3:0] mask_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            mask_q <= {LDC_MASK_RST, LDC_MASK_RST};
        else
            for (int g = 0; g < LDC_GROUPS; g++)
            begin
                if (wr_mclr[g])
                    mask_q[g] <= LDC_MASK_RST; // RQ6 RQ15
                else if (wr_mskclr[g])
                    mask_q[g] <= LDC_ZERO4; // RQ17
                else if (wr_smask[g])
                    mask_q[g][io_req.wdata[LDC_SEL_LSB +: LDC_SEL_W]] <=
                        io_req.wdata[LDC_SET_BIT]; // RQ5
                else if (g == 1 && wr_all)
                    mask_q[g] <= io_req.wdata[3:0]; // RQ18
            end
    end

    // -----------------------------------------------------------------
    // channel mode and cycle timing
    // -----------------------------------------------------------------
    logic [7:0][1:0] tim_q;
    ldc_mode_type [7:0] mode_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            mode_q <= {LDC_CHANS{LDC_MODE_RST}};
        else
            for (int g = 0; g < LDC_GROUPS; g++)
                if (wr_mode[g])
                begin
                    mode_q[chan_of(g, io_req.wdata)] <= '{ // RQ20
                        xfer_mode: io_req.wdata[LDC_MODE_XM_LSB +: 2],
                        addr_dec: io_req.wdata[LDC_MODE_DEC_BIT], // RQ9
                        auto_init: io_req.wdata[LDC_MODE_AUTO_BIT], // RQ8
                        xfer_type: io_req.wdata[LDC_MODE_TYPE_LSB +: 2]
                    }; // RQ7 RQ10
                end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            tim_q <= {LDC_CHANS{LDC_TIM_RST}};
        else
            for (int g = 0; g < LDC_GROUPS; g++)
                if (wr_tim[g])
                    tim_q[chan_of(g, io_req.wdata)] <=
                        io_req.wdata[LDC_TIM_LSB +: 2]; // RQ11
    end

    assign chan_mode = mode_q;
    assign chan_timing = tim_q;

    // -----------------------------------------------------------------
    // byte pointers
    // -----------------------------------------------------------------
    logic [1:0] bptr_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            bptr_q <= '0; // RQ14
        else
            for (int g = 0; g < LDC_GROUPS; g++)
            begin
                if (wr_pclr[g] || wr_mclr[g])
                    bptr_q[g] <= 1'b0; // RQ13 RQ15
                else if (byte_ptr_flip[g])
                    bptr_q[g] <= ~bptr_q[g];
            end
    end

    assign byte_ptr = bptr_q;

    // -----------------------------------------------------------------
    // terminal count status
    // -----------------------------------------------------------------
    logic [7:0] tc_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            tc_q <= '0;
        else
            for (int i = 0; i < LDC_CHANS; i++)
            begin
                if (wr_mclr[i / LDC_CH_PER_GRP])
                    tc_q[i] <= 1'b0; // RQ22
                else if (engine_tc[i])
                    tc_q[i] <= 1'b1;
                else if (rd_stat[i / LDC_CH_PER_GRP])
                    tc_q[i] <= 1'b0;
            end
    end

    // -----------------------------------------------------------------
    // service gating and acknowledge pins
    // -----------------------------------------------------------------
    logic [7:0] req_any, svc_q, ack_q;

    assign req_any = hw_req | sw_req_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            svc_q <= '0;
            ack_q <= '1;
        end
        else
            for (int i = 0; i < LDC_CHANS; i++)
            begin
                svc_q[i] <= req_any[i] & ~mask_q[i / 4][i % 4]
                    & ~cmd_q[i / 4][LDC_CMD_DIS_BIT]; // RQ1 RQ19
                ack_q[i] <= engine_ack[i]
                    ~^ cmd_q[i / 4][LDC_CMD_ACK_POL_BIT]; // RQ3
            end
    end

    assign service_req = svc_q;
    assign channel_acknowledge_line = ack_q;

    // -----------------------------------------------------------------
    // read data
    // -----------------------------------------------------------------
    logic [7:0] rdata_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= LDC_RD_NONE;
        else if (io_req.rd)
        begin
            if (rd_stat[0])
                rdata_q <= {req_any[3:0], tc_q[3:0]}; // RQ22
            else if (rd_stat[1])
                rdata_q <= {req_any[7:4], tc_q[7:4]};
            else if (|rd_temp)
                rdata_q <= LDC_TEMP_VAL; // RQ16
            else if (rd_all)
                rdata_q <= {LDC_ZERO4, mask_q[1]}; // RQ18
            else
                rdata_q <= LDC_RD_NONE;
        end
    end

    assign io_rdata = rdata_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_mclr_lo;
        io_req.wr && !slave_sel && hit(io_req, LDC_ADDR_MCLR[0]);
    endsequence

    sequence s_lo_cleared;
        mask_q[0] == LDC_MASK_RST && cmd_q[0] == LDC_CMD_RST
            && bptr_q[0] == 1'b0 && sw_req_q[3:0] == LDC_ZERO4;
    endsequence

    a_mclr_resets_lo: assert property ( // RQ15
        (s_mclr_lo or (remap_en && io_req.wr
            && hit(io_req, LDC_ADDR_MCLR[0]))) |=> s_lo_cleared)
        else $error("master clear left low group state");

    a_disabled_no_svc: assert property ( // RQ1
        cmd_q[1][LDC_CMD_DIS_BIT] && $stable(cmd_q[1]) |=>
            svc_q[7:4] == LDC_ZERO4)
        else $error("disabled group still serviced");

    a_masked_no_svc: assert property ( // RQ19
        mask_q[0][2] && $stable(mask_q[0]) |=> !svc_q[2])
        else $error("masked channel serviced");

    a_clear_mask_all: assert property ( // RQ17
        wr_mskclr[1] && !wr_mclr[1] |=> mask_q[1] == LDC_ZERO4)
        else $error("clear mask left a mask set");

    a_single_mask_one: assert property ( // RQ5
        wr_smask[0] |=> (mask_q[0] & ~(4'h1 << $past(io_req.wdata[1:0])))
            == ($past(mask_q[0]) & ~(4'h1 << $past(io_req.wdata[1:0]))))
        else $error("single mask touched another channel");

    a_slave_silent: assert property ( // RQ12
        op_mode == LDC_OP_DIST_SLAVE && io_req.wr
            && hit(io_req, LDC_ADDR_CMD[0]) |=> $stable(cmd_q[0]))
        else $error("legacy write taken in slave mode");

    a_timing_always: assert property ( // RQ11
        io_req.wr && hit(io_req, LDC_ADDR_TIMING[0]) |=>
            tim_q[$past(io_req.wdata[1:0])] == $past(io_req.wdata[3:2]))
        else $error("timing write lost");

    a_ptr_clear: assert property ( // RQ13
        wr_pclr[1] ##1 !byte_ptr_flip[1] [*2] |-> !bptr_q[1])
        else $error("byte pointer not at low byte");

    a_temp_zero: assert property ( // RQ16
        rd_temp[0] |=> io_rdata == LDC_TEMP_VAL)
        else $error("temporary register not zero");

    a_mode_write: assert property ( // RQ7
        wr_mode[0] |=> mode_q[$past(io_req.wdata[1:0])].xfer_type
            == $past(io_req.wdata[3:2]))
        else $error("transfer type not stored");

    a_ack_polarity: assert property ( // RQ3
        $stable(cmd_q[0]) && !cmd_q[0][LDC_CMD_ACK_POL_BIT] && engine_ack[0]
            |=> !channel_acknowledge_line[0])
        else $error("acknowledge not active low");

endmodule // ldc_top

// File: test_legacy_dma_channel_control.sv
// self-checking bench of the legacy dma channel control block
// assumes ldc_pkg, ldc_top and the peripheral model compiled first
`timescale 1ns/1ns
module test_legacy_dma_channel_control;
    import ldc_pkg::*;
    logic clk_sys;
    logic rst_b;
    ldc_io_req_type io_req;
    logic [7:0] io_rdata;
    logic io_claim;
    logic remap_en;
    logic slave_sel;
    ldc_opmode_type op_mode;
    logic [7:0] channel_request_line;
    logic [7:0] channel_acknowledge_line;
    logic [7:0] engine_ack;
    logic [7:0] engine_tc;
    logic [1:0] byte_ptr_flip;
    logic [1:0] byte_ptr;
    logic [7:0] service_req;
    ldc_mode_type [7:0] chan_mode;
    logic [7:0][1:0] chan_timing;
    logic [7:0] want;
    logic [31:0] seed;
    logic [1:0][7:0] m_cmd;
    logic [7:0] m_mask;
    logic [7:0] m_sreq;
    logic [7:0] m_tc;
    logic [1:0] m_ptr;
    logic [7:0][5:0] m_mode;
    logic [7:0][1:0] m_tim;
    logic [7:0] d;
    int miscompares;
    int samples_checked;
    int i;

    ldc_top i_ldc_top (.clk_sys(clk_sys), .rst_b(rst_b), .io_req(io_req),
        .io_rdata(io_rdata), .io_claim(io_claim), .remap_en(remap_en),
        .slave_sel(slave_sel), .op_mode(op_mode),
        .channel_request_line(channel_request_line),
        .channel_acknowledge_line(channel_acknowledge_line),
        .engine_ack(engine_ack), .engine_tc(engine_tc),
        .byte_ptr_flip(byte_ptr_flip), .byte_ptr(byte_ptr),
        .service_req(service_req), .chan_mode(chan_mode),
        .chan_timing(chan_timing));

    ldc_periph_model i_ldc_periph_model (.want(want),
        .req_low({m_cmd[1][6], m_cmd[0][6]}),
        .channel_request_line(channel_request_line));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    function automatic logic [7:0] exp_srv();
        logic [7:0] dis;
        dis = {{4{m_cmd[1][2]}}, {4{m_cmd[0][2]}}};
        return (want | m_sreq) & ~m_mask & ~dis;
    endfunction

    function automatic logic exp_claim(input logic [15:0] a,
        input logic rd);
        logic hit_any;
        hit_any = a == LDC_ADDR_ALLMASK;
        for (int g = 0; g < 2; g++)
        begin
            if (!rd && a == LDC_ADDR_TIMING[g]) return 1'b1;
            hit_any |= a == LDC_ADDR_CMD[g] || a == LDC_ADDR_MCLR[g]
                || (!rd && (a == LDC_ADDR_SREQ[g] || a == LDC_ADDR_SMASK[g]
                || a == LDC_ADDR_MODE[g] || a == LDC_ADDR_PCLR[g]
                || a == LDC_ADDR_MSKCLR[g]));
        end
        return hit_any && (!slave_sel || remap_en);
    endfunction

    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [47:0] got, input logic [47:0] exp,
        input string what);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic model_wr(input logic [15:0] a, input logic [7:0] v);
        int g;
        int ch;
        for (g = 0; g < 2; g++)
        begin
            ch = g * 4 + v[1:0];
            if (a == LDC_ADDR_TIMING[g]) m_tim[ch] = v[3:2];
            if (!slave_sel || remap_en)
            begin
                if (a == LDC_ADDR_CMD[g]) m_cmd[g] = v & 8'hC4;
                if (a == LDC_ADDR_SREQ[g]) m_sreq[ch] = v[2];
                if (a == LDC_ADDR_SMASK[g]) m_mask[ch] = v[2];
                if (a == LDC_ADDR_MODE[g]) m_mode[ch] = v[7:2];
                if (a == LDC_ADDR_PCLR[g]) m_ptr[g] = 1'b0;
                if (a == LDC_ADDR_MSKCLR[g]) m_mask[g*4+:4] = 4'h0;
                if (a == LDC_ADDR_MCLR[g])
                begin
                    m_cmd[g] = 8'h00;
                    m_sreq[g*4+:4] = 4'h0;
                    m_tc[g*4+:4] = 4'h0;
                    m_mask[g*4+:4] = 4'hF;
                    m_ptr[g] = 1'b0;
                end
            end
        end
        if (a == LDC_ADDR_ALLMASK && (!slave_sel || remap_en))
            m_mask[7:4] = v[3:0];
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        #1;
        cmp(io_claim, exp_claim(a, 1'b0), "write claim");
        @(posedge clk_sys);
        io_req <= '0;
        model_wr(a, v);
    endtask

    task automatic io_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #1;
        cmp(io_claim, exp_claim(a, 1'b1), "read claim");
        @(posedge clk_sys);
        io_req <= '0;
        #1;
        cmp(io_rdata, e, "read data");
    endtask

    task automatic check_all();
        int n;
        n = 0;
        repeat (6) @(posedge clk_sys);
        #1;
        while (service_req !== exp_srv() && n < 12)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        cmp(service_req, exp_srv(), "service");
        cmp(byte_ptr, m_ptr, "byte pointer");
        cmp(chan_mode, m_mode, "mode");
        cmp(chan_timing, m_tim, "timing");
        if (n == 12) complete_run();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        io_req = '0;
        remap_en = 1'b0;
        slave_sel = 1'b0;
        engine_ack = 8'h00;
        engine_tc = 8'h00;
        byte_ptr_flip = 2'b00;
        want = 8'h00;
        seed = 32'h7C9E;
        m_cmd = '0;
        m_mask = 8'hFF;
        m_sreq = 8'h00;
        m_tc = 8'h00;
        m_ptr = 2'b00;
        m_mode = '0;
        m_tim = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_sys);
        cmp(channel_acknowledge_line, 8'hFF, "ack in reset");
        rst_b <= 1'b1;
        check_all();
        io_rd(LDC_ADDR_ALLMASK, 8'h0F);
        io_rd(LDC_ADDR_MCLR[0], 8'h00);
        io_rd(16'h00DF, 8'h00);
        want <= 8'h22;
        check_all();
        io_wr(LDC_ADDR_MSKCLR[0], rnd8()); check_all();
        io_wr(LDC_ADDR_SMASK[0], 8'h05); check_all();
        io_wr(LDC_ADDR_SMASK[0], 8'hF9); check_all();
        io_wr(LDC_ADDR_CMD[0], 8'h04); check_all();
        io_wr(LDC_ADDR_CMD[0], 8'h3B); check_all();
        io_wr(LDC_ADDR_SREQ[0], 8'hFE); check_all();
        io_wr(LDC_ADDR_ALLMASK, 8'hA9); check_all();
        io_rd(LDC_ADDR_ALLMASK, 8'h09);
        io_wr(LDC_ADDR_CMD[1], 8'h40); check_all();
        for (i = 0; i < 2; i++)
        begin
            io_wr(LDC_ADDR_CMD[1], {i[0], 7'h00});
            @(posedge clk_sys);
            engine_ack <= rnd8();
            repeat (2) @(posedge clk_sys);
            #1;
            cmp(channel_acknowledge_line, engine_ack ^
                {{4{~m_cmd[1][7]}}, {4{~m_cmd[0][7]}}}, "ack");
        end
        io_wr(LDC_ADDR_CMD[1], 8'h00);
        for (i = 0; i < 16; i++)
        begin
            d = rnd8();
            if (d[7:6] == 2'b11) d[7] = 1'b0;
            if (d[3:2] == 2'b11) d[3] = 1'b0;
            io_wr(LDC_ADDR_MODE[i % 2], d);
            io_wr(LDC_ADDR_TIMING[i % 2], rnd8());
            check_all();
        end
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            remap_en <= i[0];
            slave_sel <= i[1];
            @(posedge clk_sys);
            #1;
            cmp(op_mode, i[0] ? LDC_OP_DIST_MASTER : (i[1] ?
                LDC_OP_DIST_SLAVE : LDC_OP_LEGACY), "op mode");
            if (i == 2)
            begin
                io_wr(LDC_ADDR_MODE[0], 8'h55);
                io_wr(LDC_ADDR_CMD[0], 8'h04);
                io_wr(LDC_ADDR_TIMING[1], 8'h0E);
                io_wr(LDC_ADDR_MSKCLR[1], 8'h00);
                io_rd(LDC_ADDR_ALLMASK, 8'h00);
                check_all();
            end
        end
        @(posedge clk_sys);
        byte_ptr_flip <= 2'b11;
        engine_tc <= 8'h01;
        @(posedge clk_sys);
        byte_ptr_flip <= 2'b00;
        engine_tc <= 8'h00;
        m_ptr = 2'b11;
        m_tc[0] = 1'b1;
        check_all();
        io_rd(LDC_ADDR_CMD[0], {want[3:0] | m_sreq[3:0], m_tc[3:0]});
        io_rd(LDC_ADDR_CMD[0], {want[3:0] | m_sreq[3:0], 4'h0});
        io_wr(LDC_ADDR_PCLR[0], rnd8()); check_all();
        io_wr(LDC_ADDR_PCLR[1], rnd8());
        check_all();
        io_wr(LDC_ADDR_MSKCLR[1], rnd8());
        check_all();
        io_wr(LDC_ADDR_CMD[1], 8'h04);
        check_all();
        io_wr(LDC_ADDR_MCLR[0], rnd8());
        check_all();
        io_wr(LDC_ADDR_MCLR[1], rnd8()); check_all();
        io_rd(LDC_ADDR_ALLMASK, 8'h0F);
        complete_run();
    end
endmodule // test_legacy_dma_channel_control
